/* design/lsc_ctrl.sv */
// Top of the light sensor configuration and mode control block.
// Assumes a register access port from the serial bus front end and a sampled
// front end that supplies mantissa, chosen range and overload on the same clock.
//
// Function
// - A control register write aborts any conversion in progress immediately.
// - After a write, a new conversion starts if the new mode asks for one.
// - Control register at 01h, reset C810h; 15:9 and 4:0 writable, 8:5 read-only.
// - Range code 1100b means automatic ranging, chosen range reported in result exponent.
// - Range selector powers up as 1100b, automatic ranging.
// - Integration bit 11 picks 100 ms (0) or 800 ms (1) conversions.
// - Short integration drops one, two or three resolution bits on low ranges.
// - Result layout and count weight stay the same for both integration times.
// - Mode field 00 shutdown, 01 single-shot, 10 or 11 continuous.
// - Single-shot reads 01b while converting, then returns itself to 00b shutdown.
// - Entering shutdown leaves ready, high and low flags untouched.
// - Done flag set per conversion end; cleared by control read or non-shutdown write.
// - Result holds 4-bit exponent over 12-bit magnitude of latest conversion.
`timescale 1ns/1ps
`default_nettype none
module lsc_ctrl
  import lsc_pkg::*;
#(
  parameter int SHORT_CYC = LSC_SHORT_CYC,
  parameter int LONG_CYC  = LSC_LONG_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register access from the serial bus front end
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd,
  output var  logic [15:0] reg_rdata,
  // Converter front end
  input  wire logic [11:0] fe_mantissa,
  input  wire logic [3:0]  fe_auto_range,
  input  wire logic        fe_overload,
  // Limit logic outside this block
  input  wire logic        above_limit_ind,
  input  wire logic        below_limit_ind,
  // Status towards the rest of the device
  output var  logic        converting,
  output var  logic        conv_end,
  output var  logic [3:0]  range_select,
  output var  logic [4:0]  report_ctl
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [3:0]  range;
    logic        ilen;
    logic [1:0]  mode;
    logic [4:0]  misc;
    logic        ovl;
    logic        done_ind;
    logic [15:0] result;
    logic [15:0] rdata;
    logic        start;
    logic        abort;
    logic        conv_end;
  } lsc_ctl_s;

  lsc_ctl_s s_q;
  lsc_ctl_s s_d;

  lsc_conv_if cv ();

  // Number of low mantissa bits that carry no information on a short window.
  function automatic logic [1:0] lsc_res_drop(input logic [3:0] rng, input logic ilen);
    logic [1:0] n;
    n = 2'h0;
    if (!ilen) begin
      if (rng == 4'h0) begin
        n = 2'h3;
      end else if (rng >= LSC_RANGE_RES2LO && rng < LSC_RANGE_RES1) begin
        n = 2'h2;
      end else if (rng == LSC_RANGE_RES1) begin
        n = 2'h1;
      end
    end
    return n;
  endfunction

  // Full control register image as software sees it.
  function automatic logic [15:0] lsc_opctl_img(input lsc_ctl_s s, input logic hi, input logic lo);
    logic [15:0] v;
    v = {s.range, s.ilen, s.mode, s.ovl, s.done_ind, hi, lo, s.misc};
    return v;
  endfunction

  logic [3:0]  eff_range;
  logic [11:0] eff_mant;
  logic        wr_ctl;
  logic        rd_ctl;
  logic        conv_fin;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_d          = s_q;
    s_d.start    = 1'b0;
    s_d.abort    = 1'b0;
    s_d.conv_end = 1'b0;
    wr_ctl       = reg_wr && (reg_addr == LSC_OFS_OPCTL);
    rd_ctl       = reg_rd && (reg_addr == LSC_OFS_OPCTL);
    // A done pulse that meets a pending abort belongs to the aborted window and is dropped.
    conv_fin     = cv.done && !s_q.abort;
    eff_range    = (s_q.range == LSC_RANGE_AUTO) ? fe_auto_range : s_q.range;
    // Masking keeps the exponent and LSB weight unchanged; only noise bits go.
    eff_mant     = fe_mantissa & ~((12'h001 << lsc_res_drop(eff_range, s_q.ilen)) - 12'h001);

    // Clearing first lets a same-cycle completion set the flag again.
    if (rd_ctl) begin
      s_d.done_ind = 1'b0;
    end

    if (conv_fin) begin
      s_d.result   = {eff_range, eff_mant};
      s_d.ovl      = fe_overload;
      s_d.done_ind = 1'b1;
      s_d.conv_end = 1'b1;
      if (s_q.mode == LSC_MODE_SINGLE) begin
        s_d.mode = LSC_MODE_OFF;
      end else if (s_q.mode != LSC_MODE_OFF) begin
        s_d.start = 1'b1;
      end
    end

    if (wr_ctl) begin
      s_d.range = reg_wdata[LSC_RANGE_MSB:LSC_RANGE_LSB];
      s_d.ilen  = reg_wdata[LSC_ILEN_BIT];
      s_d.mode  = reg_wdata[LSC_MODE_MSB:LSC_MODE_LSB];
      s_d.misc  = reg_wdata[LSC_MISC_MSB:0];
      s_d.abort = 1'b1;
      s_d.start = (reg_wdata[LSC_MODE_MSB:LSC_MODE_LSB] != LSC_MODE_OFF);
      // A shutdown write keeps every reporting flag as it was.
      if (reg_wdata[LSC_MODE_MSB:LSC_MODE_LSB] != LSC_MODE_OFF && !conv_fin) begin
        s_d.done_ind = 1'b0;
      end
    end

    unique case (reg_addr)
      LSC_OFS_RESULT: s_d.rdata = s_q.result;
      LSC_OFS_OPCTL:  s_d.rdata = lsc_opctl_img(s_q, above_limit_ind, below_limit_ind);
      default:        s_d.rdata = 16'h0000;
    endcase
    if (!reg_rd) begin
      s_d.rdata = s_q.rdata;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.range    <= LSC_OPCTL_RESET[LSC_RANGE_MSB:LSC_RANGE_LSB];
      s_q.ilen     <= LSC_OPCTL_RESET[LSC_ILEN_BIT];
      s_q.mode     <= LSC_OPCTL_RESET[LSC_MODE_MSB:LSC_MODE_LSB];
      s_q.misc     <= LSC_OPCTL_RESET[LSC_MISC_MSB:0];
      s_q.ovl      <= LSC_OPCTL_RESET[LSC_OVL_BIT];
      s_q.done_ind <= LSC_OPCTL_RESET[LSC_DONE_BIT];
      s_q.result   <= 16'h0000;
      s_q.rdata    <= 16'h0000;
      s_q.start    <= 1'b0;
      s_q.abort    <= 1'b0;
      s_q.conv_end <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Sequencer and outputs
  // ************************************************************
  assign cv.start    = s_q.start;
  assign cv.abort    = s_q.abort;
  assign cv.long_sel = s_q.ilen;

  lsc_conv_seq #(
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_seq (
    .clk   (clk),
    .rst_n (rst_n),
    .cv    (cv)
  );

  assign reg_rdata    = s_q.rdata;
  assign converting   = cv.busy;
  assign conv_end     = s_q.conv_end;
  assign range_select = s_q.range;
  assign report_ctl   = s_q.misc;

endmodule // lsc_ctrl
`default_nettype wire

/* design/lsc_pkg.sv */
// Package for the light sensor configuration and mode control block.
// Assumes a 50 MHz system clock and the device register map with 8-bit offsets.
package lsc_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0]  LSC_OFS_RESULT    = 8'h00;
  localparam logic [7:0]  LSC_OFS_OPCTL     = 8'h01;

  // ************************************************************
  // Control register layout and reset value
  // ************************************************************
  localparam logic [15:0] LSC_OPCTL_RESET   = 16'hC810;
  localparam int          LSC_RANGE_MSB     = 15;
  localparam int          LSC_RANGE_LSB     = 12;
  localparam int          LSC_ILEN_BIT      = 11;
  localparam int          LSC_MODE_MSB      = 10;
  localparam int          LSC_MODE_LSB      = 9;
  localparam int          LSC_OVL_BIT       = 8;
  localparam int          LSC_DONE_BIT      = 7;
  localparam int          LSC_HIGH_BIT      = 6;
  localparam int          LSC_LOW_BIT       = 5;
  localparam int          LSC_MISC_MSB      = 4;
  localparam logic [3:0]  LSC_RANGE_AUTO    = 4'hC;
  localparam logic [3:0]  LSC_RANGE_RES1    = 4'h5;
  localparam logic [3:0]  LSC_RANGE_RES2LO  = 4'h1;

  // ************************************************************
  // Operating modes
  // ************************************************************
  localparam logic [1:0]  LSC_MODE_OFF      = 2'h0;
  localparam logic [1:0]  LSC_MODE_SINGLE   = 2'h1;

  // ************************************************************
  // Conversion timing
  // ************************************************************
  localparam int          LSC_CLK_HZ        = 50000000;
  localparam int          LSC_SHORT_MS      = 100;
  localparam int          LSC_LONG_MS       = 800;
  localparam int          LSC_SHORT_CYC     = LSC_CLK_HZ / 1000 * LSC_SHORT_MS;
  localparam int          LSC_LONG_CYC      = LSC_CLK_HZ / 1000 * LSC_LONG_MS;
  localparam int          LSC_CNT_W         = 26;

endpackage

/* design/lsc_conv_if.sv */
// Interface between the control register logic and the conversion sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface lsc_conv_if;
  logic start;
  logic abort;
  logic long_sel;
  logic busy;
  logic done;

  modport ctl (output start, output abort, output long_sel, input busy, input done);
  modport seq (input start, input abort, input long_sel, output busy, output done);
endinterface
`default_nettype wire

/* design/lsc_conv_seq.sv */
// Conversion sequencer: times one integration window and pulses done at its end.
// Assumes start and abort are one-cycle pulses from the control logic.
`timescale 1ns/1ps
`default_nettype none
module lsc_conv_seq
  import lsc_pkg::*;
#(
  parameter int SHORT_CYC = LSC_SHORT_CYC,
  parameter int LONG_CYC  = LSC_LONG_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control side
  lsc_conv_if.seq   cv
);

  typedef enum logic [0:0] {
    LSC_SQ_IDLE = 1'b0,
    LSC_SQ_RUN  = 1'b1
  } lsc_sq_e;

  typedef struct packed {
    lsc_sq_e              st;
    logic [LSC_CNT_W-1:0] cnt;
    logic                 done;
  } lsc_sq_s;

  lsc_sq_s s_q;
  lsc_sq_s s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    unique case (s_q.st)
      LSC_SQ_IDLE: begin
      end
      LSC_SQ_RUN: begin
        if (s_q.cnt <= LSC_CNT_W'(1)) begin
          s_d.st   = LSC_SQ_IDLE;
          s_d.done = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - LSC_CNT_W'(1);
        end
      end
    endcase
    // An abort drops the running window at once, with no done pulse.
    if (cv.abort) begin
      s_d.st   = LSC_SQ_IDLE;
      s_d.done = 1'b0;
    end
    if (cv.start) begin
      s_d.st  = LSC_SQ_RUN;
      s_d.cnt = cv.long_sel ? LSC_CNT_W'(LONG_CYC) : LSC_CNT_W'(SHORT_CYC);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{st: LSC_SQ_IDLE, cnt: '0, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign cv.busy = (s_q.st == LSC_SQ_RUN);
  assign cv.done = s_q.done;

endmodule // lsc_conv_seq
`default_nettype wire

/* test/lsc_ctrl_checker.sv */
// Concurrent checks on the ports of the light sensor control block.
// Assumes it is bound into lsc_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module lsc_ctrl_checker
  import lsc_pkg::*;
#(
  parameter int SHORT_CYC = LSC_SHORT_CYC,
  parameter int LONG_CYC  = LSC_LONG_CYC
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Watched ports
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        converting,
  input wire logic        conv_end,
  input wire logic [3:0]  range_select,
  input wire logic [4:0]  report_ctl
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic        cwr;
  logic        cwr_q;
  logic        run_q;
  logic [1:0]  mode_q;
  logic        ilen_q;
  logic [31:0] cnt_q;
  int          win;
  assign cwr = reg_wr && reg_addr == LSC_OFS_OPCTL;
  assign win = ilen_q ? LONG_CYC : SHORT_CYC;
  // The count holds the busy samples of the latest window until a control write or the start of the next one.
  // The sample right after a write still shows the aborted window, so it is skipped.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= LSC_MODE_OFF;
      ilen_q <= 1'h1;
      cnt_q  <= '0;
      cwr_q  <= 1'h0;
      run_q  <= 1'h0;
    end else begin
      if (cwr) begin
        mode_q <= reg_wdata[10:9];
        ilen_q <= reg_wdata[11];
      end
      cwr_q <= cwr;
      run_q <= converting;
      if (cwr || (converting && cwr_q)) begin
        cnt_q <= '0;
      end else if (converting) begin
        cnt_q <= run_q ? cnt_q + 32'h1 : 32'h1;
      end
    end
  end
  sequence s_run_starts;
    ##2 converting;
  endsequence
  sequence s_quiet;
    ##2 (!converting && !conv_end) [*3];
  endsequence
  a_write_starts_run: assert property (cwr && reg_wdata[10:9] != LSC_MODE_OFF |-> s_run_starts)
    else $error("Run did not start after write");
  a_off_write_aborts: assert property (cwr && reg_wdata[10:9] == LSC_MODE_OFF |-> s_quiet)
    else $error("Shutdown write did not stop the run");
  a_field_capture: assert property (cwr |=> range_select == $past(reg_wdata[15:12])
    && report_ctl == $past(reg_wdata[4:0]))
    else $error("Control fields not captured");
  a_range_holds: assert property (!cwr |=> $stable(range_select))
    else $error("Range changed without write");
  a_read_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("Read data changed without read");
  a_unmapped_zero: assert property (reg_rd && reg_addr > LSC_OFS_OPCTL |=> reg_rdata == 16'h0000)
    else $error("Unmapped read not zero");
  a_single_stops: assert property (conv_end && mode_q == LSC_MODE_SINGLE |-> !converting ##1 !converting)
    else $error("Single run restarted");
  a_cont_restarts: assert property (conv_end && mode_q[1] |-> ##[1:2] converting)
    else $error("Continuous run did not restart");
  a_window_length: assert property (conv_end |-> cnt_q == win)
    else $error("Window length wrong");
endmodule // lsc_ctrl_checker
bind lsc_ctrl lsc_ctrl_checker #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_lsc_ctrl_checker (.clk, .rst_n,
  .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .converting, .conv_end, .range_select, .report_ctl);
`default_nettype wire

/* test/lsc_host_model.sv */
// Host model that drives the register strobe port like the serial front end.
// Assumes the bench calls its tasks and shares the block clock.
`timescale 1ns/1ps
`default_nettype none
module lsc_host_model (
  // Clock
  input  wire logic        clk,
  // Register access
  output var  logic [7:0]  reg_addr,
  output var  logic        reg_wr,
  output var  logic [15:0] reg_wdata,
  output var  logic        reg_rd,
  input  wire logic [15:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'h0;
    reg_wdata = 16'h0000;
    reg_rd    = 1'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    if (a == 8'h01 && d[15:12] > 4'hC) d[15:12] = 4'hC;
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge clk);
    reg_wr    <= 1'h0;
    // Released data shows the inverse so a stale sample is caught.
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk);
    reg_rd   <= 1'h0;
    @(posedge clk);
    #1;
    d = reg_rdata;
  endtask
endmodule // lsc_host_model
`default_nettype wire

/* test/lsc_ctrl_tb_top.sv */
// Self-checking bench for the light sensor control block.
// Assumes the checker is bound in and the host model drives the register port.
`timescale 1ns/1ps
`default_nettype none
module lsc_ctrl_tb_top;
  localparam int SC = 20;
  localparam int LC = 50;
  logic        clk, rst_n, reg_wr, reg_rd, fe_overload;
  logic        above_limit_ind, below_limit_ind, converting, conv_end;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [11:0] fe_mantissa;
  logic [3:0]  fe_auto_range, range_select;
  logic [4:0]  report_ctl;
  int          n_fail, n_tests;
  lsc_ctrl #(.SHORT_CYC(SC), .LONG_CYC(LC)) u_lsc_ctrl (.clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .fe_mantissa, .fe_auto_range, .fe_overload, .above_limit_ind, .below_limit_ind,
    .converting, .conv_end, .range_select, .report_ctl);
  lsc_host_model u_lsc_host_model (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e, input string nm);
    logic [15:0] d;
    u_lsc_host_model.rd(a, d);
    chk(nm, d, e);
  endtask
  task automatic wait_end(input int lim);
    for (int i = 0; i < lim && conv_end !== 1'h1; i++) begin
      @(posedge clk);
      #1;
    end
    if (conv_end !== 1'h1) begin
      n_fail++;
      $display("Error conv_end timeout");
      report_and_stop();
    end
  endtask
  task automatic t_reset();
    rc(8'h01, 16'hC810, "control reset");
    rc(8'h02, 16'h0000, "unmapped");
    rc(8'h00, 16'h0000, "result reset");
  endtask
  task automatic t_single();
    @(posedge clk);
    fe_mantissa     <= 12'hFFF;
    fe_overload     <= 1'h1;
    above_limit_ind <= 1'h1;
    u_lsc_host_model.wr(8'h01, 16'h43E0);
    rc(8'h01, 16'h4240, "single busy");
    wait_end(SC + 10);
    rc(8'h00, 16'h4FFC, "short range4");
    rc(8'h01, 16'h41C0, "single done");
    rc(8'h01, 16'h4140, "read clears done");
  endtask
  task automatic t_auto();
    @(posedge clk);
    fe_auto_range <= 4'h3;
    u_lsc_host_model.wr(8'h01, 16'hC600);
    wait_end(SC + 10);
    rc(8'h00, 16'h3FFC, "auto exponent");
    @(posedge clk);
    fe_mantissa <= 12'h123;
    wait_end(SC + 10);
    rc(8'h00, 16'h3120, "restart result");
    @(posedge clk);
    fe_mantissa <= 12'h456;
    u_lsc_host_model.wr(8'h01, 16'hC000);
    rc(8'h01, 16'hC1C0, "off keeps flags");
    repeat (SC + 5) @(posedge clk);
    rc(8'h00, 16'h3120, "aborted result");
  endtask
  task automatic t_long();
    @(posedge clk);
    fe_mantissa     <= 12'hFFF;
    below_limit_ind <= 1'h1;
    u_lsc_host_model.wr(8'h01, 16'h0C00);
    wait_end(LC + 10);
    rc(8'h00, 16'h0FFF, "long range0");
    u_lsc_host_model.wr(8'h01, 16'h0800);
    rc(8'h01, 16'h09E0, "off keeps done");
    u_lsc_host_model.wr(8'h01, 16'h0200);
    wait_end(SC + 10);
    u_lsc_host_model.wr(8'h01, 16'h0200);
    rc(8'h01, 16'h0360, "write clears done");
    wait_end(SC + 10);
    rc(8'h00, 16'h0FF8, "short range0");
  endtask
  initial begin
    n_fail          = 0;
    n_tests         = 0;
    rst_n           = 1'h0;
    fe_mantissa     = 12'h000;
    fe_auto_range   = 4'h0;
    fe_overload     = 1'h0;
    above_limit_ind = 1'h0;
    below_limit_ind = 1'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_single();
    t_auto();
    t_long();
    report_and_stop();
  end
endmodule // lsc_ctrl_tb_top
`default_nettype wire
